// *** core/pwm_pkg.sv ***
// Constants, register map and field layout of the motor pulse generator.
// Assumes a 16-bit register port and a 100 MHz system clock.
`default_nettype none

package pwm_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int PAIRS = 3;
  localparam int CHANNELS = 6;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_CONFIG = 4'h1;
  localparam logic [3:0] OFF_MODULUS = 4'h2;
  localparam logic [3:0] OFF_DEADTIME = 4'h3;
  localparam logic [3:0] OFF_VALUE0 = 4'h4;
  localparam logic [3:0] OFF_FAULT_CTRL = 4'hA;
  localparam logic [3:0] OFF_STATUS = 4'hB;
  localparam logic [3:0] OFF_MASK = 4'hC;
  localparam logic [3:0] OFF_COUNTER = 4'hD;
  localparam logic [3:0] OFF_PINS = 4'hE;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTL_ENABLE = 0;
  localparam int CTL_CENTER = 1;
  localparam int CTL_LOAD_OK = 2;
  localparam int CTL_CORRECT = 3;
  localparam int CTL_RELOAD_LSB = 4;
  localparam int CFG_INDEP_LSB = 0;
  localparam int CFG_POL_TOP = 4;
  localparam int CFG_POL_BOTTOM = 5;
  localparam int FLT_EN_LSB = 0;
  localparam int FLT_AUTO_LSB = 4;
  localparam int ST_RELOAD = 0;
  localparam int ST_FAULT_LSB = 1;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_CONFIG = 16'h0000;
  localparam logic [15:0] RST_MODULUS = 16'h0064;
  localparam logic [15:0] RST_DEADTIME = 16'h0000;
  localparam logic [15:0] RST_VALUE = 16'h0000;
  localparam logic [15:0] RST_FAULT_CTRL = 16'h0000;
  localparam logic [3:0] RST_MASK = 4'h0;

endpackage

`default_nettype wire

// *** core/pwm_pair_if.sv ***
// Signals between the generator core and one output pair.
// Assumes one clock domain shared by both ends.
`default_nettype none

interface pwm_pair_if;
  logic [15:0] count;
  logic [15:0] value_top;
  logic [15:0] value_bottom;
  logic [15:0] dead;
  logic indep;
  logic pol_top;
  logic pol_bottom;
  logic run;
  logic out_top;
  logic out_bottom;

  modport core (
    output count, value_top, value_bottom, dead, indep, pol_top, pol_bottom, run,
    input out_top, out_bottom
  );
  modport pair (
    input count, value_top, value_bottom, dead, indep, pol_top, pol_bottom, run,
    output out_top, out_bottom
  );
endinterface

`default_nettype wire

// *** core/pwm_pair.sv ***
// One output pair: compare, dead interval, polarity, shutdown.
// Assumes a synchronised active-low reset from the top module.
`default_nettype none

module pwm_pair (
  input wire logic i_clock,
  input wire logic i_rst_n,
  pwm_pair_if.pair bus
);
  import pwm_pkg::*;

  logic raw_top;
  logic raw_bottom;
  logic side;
  logic [15:0] dead_count;
  logic on_top;
  logic on_bottom;

  // ----------------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------------
  assign raw_top = bus.count < bus.value_top;
  assign raw_bottom = bus.count < bus.value_bottom;

  // ----------------------------------------------------------------------
  // Dead interval
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      side <= 1'b0;
      dead_count <= 16'h0000;
    end else if (raw_top != side) begin
      side <= raw_top;
      dead_count <= bus.dead;
    end else if (dead_count != 16'h0000) begin
      dead_count <= dead_count - 16'h0001;
    end
  end

  always_comb begin
    if (bus.indep) begin
      on_top = raw_top;
      on_bottom = raw_bottom;
    end else begin
      on_top = side && dead_count == 16'h0000;
      on_bottom = !side && dead_count == 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus.out_top <= 1'b0;
      bus.out_bottom <= 1'b0;
    end else begin
      bus.out_top <= (on_top && bus.run) ^ bus.pol_top;
      bus.out_bottom <= (on_bottom && bus.run) ^ bus.pol_bottom;
    end
  end
endmodule

`default_nettype wire

// *** core/motor_pwm_generator.sv ***
// Motor pulse generator: counter, registers, reload, protection, sync.
// Assumes a 16-bit register port with read data one cycle after the strobe.
//
// Operation
// - Six outputs: three pairs or six channels
// - Dead interval between complementary side changes
// - Separate top and bottom output polarity
// - Counter runs up to programmable modulus
// - Edge or center aligned, zero to full
// - Three current-sense and three fault inputs
// - Fault protection, cycle-by-cycle current limiting
// - Current sense selects software correction values
// - Key parameters accept only first write
// - Buffered values load every 1 to 16 periods
// - Reference sync output for converter timer
// - Reload event driven out as sync pulse
//
// The register offsets and strobed register access were decided locally.
`default_nettype none

module motor_pwm_generator (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [pwm_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pwm_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [pwm_pkg::PAIRS-1:0] i_fault,
  input wire logic [pwm_pkg::PAIRS-1:0] i_current_sense,
  output logic [pwm_pkg::DATA_W-1:0] o_rdata,
  output logic [pwm_pkg::PAIRS-1:0] o_pwm_top,
  output logic [pwm_pkg::PAIRS-1:0] o_pwm_bottom,
  output logic o_sync,
  output logic o_irq
);
  import pwm_pkg::*;

  typedef enum logic [1:0] {
    COUNT_UP = 2'b01,
    COUNT_DOWN = 2'b10
  } dir_t;

  logic [1:0] rst_sync;
  logic rst_n;
  logic [15:0] control;
  logic [15:0] config_reg;
  logic config_locked;
  logic [15:0] modulus_buf;
  logic [15:0] modulus;
  logic [15:0] deadtime;
  logic deadtime_locked;
  logic [15:0] value_buf [CHANNELS];
  logic [15:0] value [CHANNELS];
  logic center;
  logic [15:0] fault_ctrl;
  logic [3:0] status;
  logic [3:0] mask;
  logic [PAIRS-1:0] fault_hold;
  logic [15:0] count;
  dir_t dir;
  logic [3:0] period_count;
  logic period_end;
  logic reload;
  logic write_status;
  logic [3:0] set_status;

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
    hit = addr == off;
  endfunction

  function automatic logic set_wins(input logic old, input logic set, input logic clr);
    set_wins = set || (old && !clr);
  endfunction

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------------
  always_comb begin
    if (!control[CTL_ENABLE]) begin
      period_end = 1'b0;
    end else if (center) begin
      period_end = dir == COUNT_DOWN && count <= 16'h0001;
    end else begin
      period_end = count + 16'h0001 >= modulus;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      dir <= COUNT_UP;
    end else if (!control[CTL_ENABLE] || period_end) begin
      count <= 16'h0000;
      dir <= COUNT_UP;
    end else begin
      case (dir)
        COUNT_UP: begin
          if (center && count + 16'h0001 >= modulus) begin
            dir <= COUNT_DOWN;
          end
          count <= count + 16'h0001;
        end
        COUNT_DOWN: begin
          count <= count - 16'h0001;
        end
        default: begin
          dir <= COUNT_UP;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Reload rate
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      period_count <= 4'h0;
    end else if (!control[CTL_ENABLE] || reload) begin
      period_count <= 4'h0;
    end else if (period_end) begin
      period_count <= period_count + 4'h1;
    end
  end
  assign reload = period_end &&
    period_count == control[CTL_RELOAD_LSB +: 4];

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      control <= RST_CONTROL;
    end else begin
      if (i_write && hit(i_addr, OFF_CONTROL)) begin
        control <= i_wdata;
      end else if (reload || !control[CTL_ENABLE]) begin
        control[CTL_LOAD_OK] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= RST_CONFIG;
      config_locked <= 1'b0;
      deadtime <= RST_DEADTIME;
      deadtime_locked <= 1'b0;
    end else begin
      if (i_write && hit(i_addr, OFF_CONFIG) && !config_locked) begin
        config_reg <= i_wdata;
        config_locked <= 1'b1;
      end
      if (i_write && hit(i_addr, OFF_DEADTIME) && !deadtime_locked) begin
        deadtime <= i_wdata;
        deadtime_locked <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_ctrl <= RST_FAULT_CTRL;
      mask <= RST_MASK;
      modulus_buf <= RST_MODULUS;
    end else if (i_write) begin
      if (hit(i_addr, OFF_FAULT_CTRL)) begin
        fault_ctrl <= i_wdata;
      end
      if (hit(i_addr, OFF_MASK)) begin
        mask <= i_wdata[3:0];
      end
      if (hit(i_addr, OFF_MODULUS)) begin
        modulus_buf <= i_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Double buffer
  // ----------------------------------------------------------------------
  logic load_now;
  assign load_now = control[CTL_LOAD_OK] && (reload || !control[CTL_ENABLE]);

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      modulus <= RST_MODULUS;
      center <= 1'b0;
    end else if (load_now) begin
      modulus <= modulus_buf;
      center <= control[CTL_CENTER];
    end
  end

  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_value
      always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
          value_buf[c] <= RST_VALUE;
          value[c] <= RST_VALUE;
        end else begin
          if (i_write && hit(i_addr, OFF_VALUE0 + 4'(c))) begin
            value_buf[c] <= i_wdata;
          end
          if (load_now) begin
            value[c] <= value_buf[c];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Protection
  // ----------------------------------------------------------------------
  generate
    for (genvar p = 0; p < PAIRS; p++) begin : g_fault
      logic trip;
      logic release_now;
      assign trip = fault_ctrl[FLT_EN_LSB + p] && i_fault[p];
      assign release_now = !i_fault[p] && (fault_ctrl[FLT_AUTO_LSB + p] ?
        period_end : write_status && i_wdata[ST_FAULT_LSB + p]);
      always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
          fault_hold[p] <= 1'b0;
        end else begin
          fault_hold[p] <= set_wins(fault_hold[p], trip, release_now);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------------
  assign write_status = i_write && hit(i_addr, OFF_STATUS);
  assign set_status = {fault_ctrl[FLT_EN_LSB +: PAIRS] & i_fault, reload};

  generate
    for (genvar s = 0; s < 4; s++) begin : g_status
      always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
          status[s] <= 1'b0;
        end else begin
          status[s] <= set_wins(status[s], set_status[s], write_status && i_wdata[s]);
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      o_irq <= |(status & mask);
      o_sync <= reload;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 16'h0000;
    end else if (!i_read) begin
      o_rdata <= 16'h0000;
    end else begin
      case (i_addr)
        OFF_CONTROL: o_rdata <= control;
        OFF_CONFIG: o_rdata <= config_reg;
        OFF_MODULUS: o_rdata <= modulus_buf;
        OFF_DEADTIME: o_rdata <= deadtime;
        OFF_FAULT_CTRL: o_rdata <= fault_ctrl;
        OFF_STATUS: o_rdata <= {12'h000, status};
        OFF_MASK: o_rdata <= {12'h000, mask};
        OFF_COUNTER: o_rdata <= count;
        OFF_PINS: o_rdata <= {5'h00, fault_hold, 1'b0, i_current_sense, 1'b0, i_fault};
        default: begin
          if (i_addr >= OFF_VALUE0 && i_addr < OFF_FAULT_CTRL) begin
            o_rdata <= value_buf[3'(i_addr - OFF_VALUE0)];
          end else begin
            o_rdata <= 16'h0000;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Output pairs
  // ----------------------------------------------------------------------
  generate
    for (genvar p = 0; p < PAIRS; p++) begin : g_pair
      pwm_pair_if link ();
      logic use_alt;
      assign use_alt = control[CTL_CORRECT] && i_current_sense[p];
      assign link.count = count;
      assign link.indep = config_reg[CFG_INDEP_LSB + p];
      assign link.value_top = (!link.indep && use_alt) ? value[2*p+1] : value[2*p];
      assign link.value_bottom = value[2*p+1];
      assign link.dead = deadtime;
      assign link.pol_top = config_reg[CFG_POL_TOP];
      assign link.pol_bottom = config_reg[CFG_POL_BOTTOM];
      assign link.run = control[CTL_ENABLE] && !fault_hold[p] &&
        !(fault_ctrl[FLT_EN_LSB + p] && i_fault[p]);
      assign o_pwm_top[p] = link.out_top;
      assign o_pwm_bottom[p] = link.out_bottom;
      pwm_pair u_pair (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .bus(link.pair)
      );
    end
  endgenerate
endmodule

`default_nettype wire

// *** test/motor_pwm_generator_props.sv ***
// Port checker for the motor pulse generator.
// Assumes it is bound to the generator top module.
`default_nettype none

module motor_pwm_generator_props
  import pwm_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [pwm_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pwm_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [pwm_pkg::PAIRS-1:0] i_fault,
  input wire logic [pwm_pkg::PAIRS-1:0] i_current_sense,
  input wire logic [pwm_pkg::DATA_W-1:0] o_rdata,
  input wire logic [pwm_pkg::PAIRS-1:0] o_pwm_top,
  input wire logic [pwm_pkg::PAIRS-1:0] o_pwm_bottom,
  input wire logic o_sync,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // Shadow of written settings
  // ----------------------------------------------------------------------
  logic [5:0] cfg;
  logic [5:0] cfg_d1;
  logic [5:0] cfg_d2;
  logic locked;
  logic [2:0] fen;
  logic [3:0] mask;
  logic [2:0] quiet;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg <= 6'h00;
      cfg_d1 <= 6'h00;
      cfg_d2 <= 6'h00;
      locked <= 1'b0;
      fen <= 3'h0;
      mask <= 4'h0;
      quiet <= 3'h0;
    end else begin
      if (i_write && i_addr == OFF_CONFIG && !locked) begin
        cfg <= i_wdata[5:0] & 6'h37;
        locked <= 1'b1;
      end
      if (i_write && i_addr == OFF_FAULT_CTRL) begin
        fen <= i_wdata[2:0];
      end
      if (i_write && i_addr == OFF_MASK) begin
        mask <= i_wdata[3:0];
      end
      cfg_d1 <= cfg;
      cfg_d2 <= cfg_d1;
      if ($changed(i_fault) || $changed(i_current_sense)) begin
        quiet <= 3'h0;
      end else if (quiet != 3'h7) begin
        quiet <= quiet + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  a_rdata_idle: assert property (
    !$past(i_read) |-> o_rdata == 16'h0000) else $error("read data not idle");
  a_config_lock: assert property (
    $past(i_read) && $past(i_addr) == OFF_CONFIG |-> (o_rdata[5:0] & 6'h37) == cfg)
    else $error("config not held at first write");
  a_no_overlap: assert property (
    cfg == cfg_d2 |->
    ((o_pwm_top ^ {3{cfg[4]}}) & (o_pwm_bottom ^ {3{cfg[5]}}) & ~cfg[2:0]) == 3'h0)
    else $error("both sides of a pair active");
  a_fault_off: assert property (
    i_fault[0] && fen[0] |-> ##[1:4] (o_pwm_top[0] == cfg[4] && o_pwm_bottom[0] == cfg[5]))
    else $error("pair not forced inactive by fault");
  a_irq_masked: assert property (
    mask == 4'h0 && $past(mask) == 4'h0 |-> !o_irq) else $error("masked interrupt seen");
  a_irq_sticky: assert property (
    o_irq && !i_write && !$past(i_write) |=> o_irq) else $error("interrupt dropped alone");
  a_sync_irq: assert property (
    o_sync && mask[0] |-> ##[0:2] o_irq) else $error("sync without reload interrupt");
  a_pins_read: assert property (
    quiet == 3'h7 && $past(i_read) && $past(i_addr) == OFF_PINS |->
    o_rdata[2:0] == i_fault && o_rdata[6:4] == i_current_sense)
    else $error("pin levels read wrong");
endmodule

`default_nettype wire

// *** test/pwm_stage_model.sv ***
// Power stage with fault and current sensing; counts gate on-time.
// Assumes the bench commands trips and sense levels at clock edges.
`default_nettype none

module pwm_stage_model (
  input wire logic i_clock,
  input wire logic [2:0] i_gate_top,
  input wire logic [2:0] i_gate_bottom,
  input wire logic i_pol_top,
  input wire logic i_pol_bottom,
  input wire logic i_clear,
  input wire logic [2:0] i_trip,
  input wire logic [2:0] i_sense_req,
  output logic [2:0] o_fault,
  output logic [2:0] o_sense,
  output logic [2:0][15:0] o_top_time,
  output logic [2:0][15:0] o_bottom_time
);
  timeunit 1ns;
  timeprecision 1ns;

  // Sensors lag the bench command by one cycle
  always_ff @(posedge i_clock) begin
    o_fault <= i_trip;
    o_sense <= i_sense_req;
  end

  // Active time per gate, polarity removed
  always_ff @(posedge i_clock) begin
    for (int p = 0; p < 3; p++) begin
      if (i_clear) begin
        o_top_time[p] <= 16'h0000;
        o_bottom_time[p] <= 16'h0000;
      end else begin
        o_top_time[p] <= o_top_time[p] + 16'(i_gate_top[p] ^ i_pol_top);
        o_bottom_time[p] <= o_bottom_time[p] + 16'(i_gate_bottom[p] ^ i_pol_bottom);
      end
    end
  end
endmodule

`default_nettype wire

// *** test/test_motor_pwm_generator.sv ***
// Self-checking bench for the motor pulse generator.
// Assumes the stage model and the port checker are compiled first.
`default_nettype none

`define CHECK(name, exp, got) \
  begin checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch %s expected %0h seen %0h", name, exp, got); end end

module test_motor_pwm_generator;
  timeunit 1ns;
  timeprecision 1ns;
  import pwm_pkg::*;

  logic i_clock = 1'b0;
  logic i_reset_n, i_write, i_read, clear, pol_t, pol_b;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata;
  logic [2:0] i_fault, i_current_sense, trip, sense, o_pwm_top, o_pwm_bottom;
  logic o_sync, o_irq;
  logic [2:0][15:0] t_on, b_on;
  int fail_count = 0;
  int checks = 0;
  int syncs;

  motor_pwm_generator i_dut (.i_clock, .i_reset_n, .i_addr, .i_wdata, .i_write, .i_read,
    .i_fault, .i_current_sense, .o_rdata, .o_pwm_top, .o_pwm_bottom, .o_sync, .o_irq);
  pwm_stage_model i_stage (.i_clock, .i_gate_top(o_pwm_top), .i_gate_bottom(o_pwm_bottom),
    .i_pol_top(pol_t), .i_pol_bottom(pol_b), .i_clear(clear), .i_trip(trip),
    .i_sense_req(sense), .o_fault(i_fault), .o_sense(i_current_sense),
    .o_top_time(t_on), .o_bottom_time(b_on));

  initial begin
    forever #5 i_clock = ~i_clock;
  end

  // ----------------------------------------------------------------------
  // Bus and measurement tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e,
                        input string n);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1;
    `CHECK(n, e, o_rdata & m)
  endtask

  task automatic run(input int n);
    @(posedge i_clock);
    clear <= 1'b1;
    @(posedge i_clock);
    clear <= 1'b0;
    syncs = 0;
    repeat (n) begin
      @(posedge i_clock);
      #1;
      syncs += int'(o_sync);
    end
  endtask

  task automatic do_reset();
    i_reset_n <= 1'b0;
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_clock);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_lock();
    rd_chk(OFF_MODULUS, 16'hFFFF, 16'h0064, "modulus");
    rd_chk(OFF_CONTROL, 16'hFFFF, 16'h0000, "control");
    rd_chk(OFF_COUNTER, 16'hFFFF, 16'h0000, "counter");
    wr(OFF_CONFIG, 16'h0030);
    wr(OFF_CONFIG, 16'h0027);
    wr(OFF_DEADTIME, 16'h0002);
    wr(OFF_DEADTIME, 16'h0005);
    rd_chk(OFF_CONFIG, 16'h0037, 16'h0030, "config");
    rd_chk(OFF_DEADTIME, 16'hFFFF, 16'h0002, "dead time");
    rd_chk(4'hF, 16'hFFFF, 16'h0000, "unmapped");
    `CHECK("idle top", 3'b111, o_pwm_top)
    `CHECK("idle bottom", 3'b111, o_pwm_bottom)
    $display("test lock done");
  endtask

  task automatic t_edge();
    wr(OFF_MODULUS, 16'h000A);
    wr(OFF_VALUE0, 16'h0000);
    wr(OFF_VALUE0 + 4'h2, 16'h000B);
    wr(OFF_VALUE0 + 4'h4, 16'h0004);
    rd_chk(OFF_VALUE0 + 4'h4, 16'hFFFF, 16'h0004, "value buffer");
    wr(OFF_MASK, 16'h0001);
    wr(OFF_CONTROL, 16'h0004);
    wr(OFF_CONTROL, 16'h0005);
    run(20);
    run(20);
    `CHECK("sync count", 2, syncs)
    `CHECK("top time", {16'd4, 16'd20, 16'd0}, t_on)
    `CHECK("bottom time", {16'd8, 16'd0, 16'd20}, b_on)
    `CHECK("irq", 1'b1, o_irq)
    for (int r = 0; r < 16; r++) begin
      wr(OFF_CONTROL, 16'h0005 | 16'(r << 4));
      run(10 * (r + 1));
      run(20 * (r + 1));
      `CHECK("reload rate", 2, syncs)
    end
    wr(OFF_CONTROL, 16'h0007);
    run(200);
    run(40);
    `CHECK("center sync", 2, syncs)
    `CHECK("center top", {16'd10, 16'd40, 16'd0}, t_on)
    `CHECK("center bottom", {16'd22, 16'd0, 16'd40}, b_on)
    wr(OFF_MASK, 16'h0000);
    run(4);
    `CHECK("masked irq", 1'b0, o_irq)
    $display("test edge done");
  endtask

  task automatic t_fault();
    wr(OFF_CONTROL, 16'h0005);
    wr(OFF_FAULT_CTRL, 16'h0001);
    wr(OFF_STATUS, 16'h000F);
    wr(OFF_MASK, 16'h0002);
    run(30);
    trip <= 3'b001;
    run(10);
    `CHECK("fault bottom", 3'b001, o_pwm_bottom & 3'b001)
    `CHECK("fault irq", 1'b1, o_irq)
    rd_chk(OFF_PINS, 16'h0101, 16'h0101, "pins");
    @(posedge i_clock);
    trip <= 3'b000;
    run(30);
    `CHECK("fault held", 16'd0, b_on[0])
    wr(OFF_STATUS, 16'h0002);
    run(20);
    run(20);
    `CHECK("fault cleared", 16'd20, b_on[0])
    wr(OFF_FAULT_CTRL, 16'h0011);
    trip <= 3'b001;
    run(2);
    trip <= 3'b000;
    run(20);
    run(20);
    `CHECK("auto release", 16'd20, b_on[0])
    $display("test fault done");
  endtask

  task automatic t_correct();
    wr(OFF_VALUE0 + 4'h1, 16'h000A);
    wr(OFF_CONTROL, 16'h000D);
    sense <= 3'b001;
    run(20);
    run(20);
    `CHECK("corrected top", 16'd20, t_on[0])
    sense <= 3'b000;
    run(20);
    run(20);
    `CHECK("plain top", 16'd0, t_on[0])
    $display("test correct done");
  endtask

  task automatic t_indep();
    do_reset();
    pol_t <= 1'b0;
    pol_b <= 1'b0;
    wr(OFF_CONFIG, 16'h0007);
    wr(OFF_MODULUS, 16'h000A);
    wr(OFF_VALUE0, 16'h000A);
    wr(OFF_VALUE0 + 4'h1, 16'h000A);
    wr(OFF_CONTROL, 16'h0004);
    wr(OFF_CONTROL, 16'h0005);
    run(20);
    run(20);
    `CHECK("indep top", 16'd20, t_on[0])
    `CHECK("indep bottom", 16'd20, b_on[0])
    $display("test indep done");
  endtask

  initial begin
    i_reset_n = 1'b0;
    i_write = 1'b0;
    i_read = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    trip = 3'b000;
    sense = 3'b000;
    clear = 1'b0;
    pol_t = 1'b1;
    pol_b = 1'b1;
    do_reset();
    t_lock();
    t_edge();
    t_fault();
    t_correct();
    t_indep();
    test_done();
  end
endmodule

bind motor_pwm_generator motor_pwm_generator_props i_props (.i_clock, .i_reset_n, .i_addr,
  .i_wdata, .i_write, .i_read, .i_fault, .i_current_sense, .o_rdata, .o_pwm_top,
  .o_pwm_bottom, .o_sync, .o_irq);

`undef CHECK
`default_nettype wire
